// file: rtl/sps_dev.sv
// Chosen here: a write-only I2C slave port on sps_i2c_if.
`timescale 1ns/1ps
module sps_dev
  import sps_pkg::*;
#(
  parameter logic [6:0] CHIP_ADDR = SPS_CHIP_ADDR,
  parameter int         CLAMP_CYC = SPS_CLAMP_CYC,
  parameter int         VERT_CYC  = SPS_VERT_CYC
)(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic ce,
  sps_i2c_if.dev    bus,
  input  wire logic supply_above_8v3,
  input  wire logic supply_above_8v1,
  input  wire logic overvoltage_trip_in,
  input  wire logic loop_node_grounded,
  input  wire logic unlock_status,
  output logic      horiz_drive_oe,
  output logic      supply_drive_oe,
  output logic      vert_out_en,
  output logic      lock_loss_flag_o,
  output logic      lock_loss_flag_oe,
  output logic      clamp_blank_continuous,
  output logic      loop_filter_discharge,
  output logic      standby_status
);
  initial
  begin
    if (CLAMP_CYC < 1 || CLAMP_CYC > 4096 || VERT_CYC < 1 || VERT_CYC > 4096)
      $error("sps_dev: sequence delays must be 1 to 4096 cycles.");
  end

  typedef struct packed {
    logic [1:0] s83;
    logic [1:0] s81;
    logic [1:0] ovp;
    logic [1:0] gnd;
    logic [1:0] scl;
    logic [1:0] sda;
    logic       scl_p;
    logic       sda_p;
    logic       unl;
    sps_ph_t    ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] sub;
    logic       ack;
    logic [7:0] ctrl;
    logic       reload;
    logic       low;
    logic       dip;
    logic       ovpl;
    logic       resume;
    sps_seq_t   seq;
    logic [11:0] tmr;
  } sps_dev_st_t;

  sps_dev_st_t q;
  sps_dev_st_t d;

  logic sup83;
  logic sup81;
  logic gnd;
  logic scl_r;
  logic scl_f;
  logic start;
  logic stop;
  logic standby;
  logic data_wr;
  logic soft_wr;
  logic go;

  always_comb
  begin
    d = q;
    d.s83 = {q.s83[0], supply_above_8v3};
    d.s81 = {q.s81[0], supply_above_8v1};
    d.ovp = {q.ovp[0], overvoltage_trip_in};
    d.gnd = {q.gnd[0], loop_node_grounded};
    d.scl = {q.scl[0], bus.scl};
    d.sda = {q.sda[0], bus.sda};
    d.scl_p = q.scl[1];
    d.sda_p = q.sda[1];
    d.unl = unlock_status;
    sup83 = q.s83[1];
    sup81 = q.s81[1];
    gnd = q.gnd[1];
    scl_r = q.scl[1] & ~q.scl_p;
    scl_f = ~q.scl[1] & q.scl_p;
    start = q.scl[1] & q.scl_p & q.sda_p & ~q.sda[1];
    stop = q.scl[1] & q.scl_p & ~q.sda_p & q.sda[1];
    standby = (q.seq != SPS_SEQ_RUN);
    data_wr = 1'b0;
    soft_wr = 1'b0;
    go = 1'b0;

    // Write-only slave: address, subaddress, then data bytes.
    if (start)
    begin
      d.ph = SPS_PH_ADDR;
      d.cnt = 4'h0;
      d.ack = 1'b0;
    end
    else if (stop)
    begin
      d.ph = SPS_PH_IDLE;
      d.ack = 1'b0;
    end
    else if (q.ph != SPS_PH_IDLE)
    begin
      if (scl_r && q.cnt < 4'h8)
      begin
        d.sh = {q.sh[6:0], q.sda[1]};
        d.cnt = q.cnt + 4'h1;
      end
      if (scl_f && q.cnt == 4'h8)
      begin
        d.cnt = 4'h9;
        case (q.ph)
          SPS_PH_ADDR: d.ack = sup83 & (q.sh[7:1] == CHIP_ADDR) & ~q.sh[0];
          SPS_PH_SUB:
          begin
            d.ack = sup83;
            d.sub = q.sh;
          end
          default:
          begin
            d.ack = sup83 & (~standby | (q.sub == SPS_SUB_CTRL));
            data_wr = d.ack;
          end
        endcase
      end
      if (scl_f && q.cnt == 4'h9)
      begin
        d.ack = 1'b0;
        d.cnt = 4'h0;
        if (!q.ack)
          d.ph = SPS_PH_IDLE;
        else if (q.ph == SPS_PH_ADDR)
          d.ph = SPS_PH_SUB;
        else if (q.ph == SPS_PH_SUB)
          d.ph = SPS_PH_DATA;
        else
          d.sub = q.sub + 8'h01;
      end
    end

    // A stored byte counts as a reload; the control byte lives at 1AH.
    if (data_wr)
    begin
      d.reload = 1'b1;
      if (q.sub == SPS_SUB_CTRL)
      begin
        d.ctrl = q.sh;
        soft_wr = q.sh[SPS_BIT_SOFT] & ~q.sh[SPS_BIT_STBY];
      end
    end

    // Soft start needs good supply and a reload made before this write.
    if (sup83 && q.reload && !q.ctrl[SPS_BIT_STBY] && (soft_wr || q.dip))
      go = 1'b1;
    if (q.resume && !gnd && !q.low && !q.dip && !q.ovpl)
    begin
      go = 1'b1;
      d.resume = 1'b0;
    end
    if (go)
    begin
      d.low = 1'b0;
      d.dip = 1'b0;
      d.ovpl = 1'b0;
    end

    // Causes are set after the clear so that a live cause wins.
    if (!sup83 && q.seq == SPS_SEQ_OFF)
      d.low = 1'b1;
    if (q.seq != SPS_SEQ_OFF && !sup81)
      d.dip = 1'b1;
    if (q.ovp[1])
      d.ovpl = 1'b1;
    if ((d.low & ~q.low) | (d.dip & ~q.dip) | (d.ovpl & ~q.ovpl))
    begin
      d.reload = 1'b0;
      d.resume = 1'b0;
    end
    if (gnd && q.seq != SPS_SEQ_OFF && !d.low && !d.dip && !d.ovpl)
      d.resume = 1'b1;
    if (!sup83)
    begin
      d.ctrl[SPS_BIT_SOFT] = 1'b0;
      d.reload = 1'b0;
    end

    // Start-up sequence; any protection cause drops it to off at once.
    case (q.seq)
      SPS_SEQ_OFF:
      begin
        if (go)
        begin
          d.seq = SPS_SEQ_CLAMP;
          d.tmr = 12'h000;
        end
      end
      SPS_SEQ_CLAMP:
      begin
        d.tmr = q.tmr + 12'h001;
        if (q.tmr == 12'(CLAMP_CYC - 1))
        begin
          d.seq = SPS_SEQ_VERT;
          d.tmr = 12'h000;
        end
      end
      SPS_SEQ_VERT:
      begin
        d.tmr = q.tmr + 12'h001;
        if (q.tmr == 12'(VERT_CYC - 1))
        begin
          d.seq = SPS_SEQ_RUN;
          d.tmr = 12'h000;
        end
      end
      default: d.seq = SPS_SEQ_RUN;
    endcase
    if (d.low || d.dip || d.ovpl || gnd || d.ctrl[SPS_BIT_STBY])
    begin
      d.seq = SPS_SEQ_OFF;
      d.tmr = 12'h000;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.ctrl <= SPS_CTRL_RST;
      q.low <= 1'b1;
      q.ph <= SPS_PH_IDLE;
      q.seq <= SPS_SEQ_OFF;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign bus.dev_sda_oe = q.ack;
  assign horiz_drive_oe = (q.seq == SPS_SEQ_RUN);
  assign supply_drive_oe = (q.seq == SPS_SEQ_RUN);
  assign vert_out_en = (q.seq == SPS_SEQ_VERT) | (q.seq == SPS_SEQ_RUN);
  assign lock_loss_flag_o = 1'b0;
  assign lock_loss_flag_oe = (q.seq != SPS_SEQ_OFF) & ~q.unl;
  assign clamp_blank_continuous = (q.seq == SPS_SEQ_OFF);
  assign loop_filter_discharge = (q.seq == SPS_SEQ_OFF);
  assign standby_status = (q.seq != SPS_SEQ_RUN);
endmodule // sps_dev

// file: rtl/sps_host.sv
`timescale 1ns/1ps
module sps_host
  import sps_pkg::*;
#(
  parameter int HALF_CYC = SPS_SCL_HALF_CYC
)(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  sps_i2c_if.host          bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  initial
  begin
    if (HALF_CYC < 2 || HALF_CYC > 255)
      $error("sps_host: half period must be 2 to 255 cycles.");
  end

  typedef struct packed {
    logic       rdy;
    logic [31:0] rdata;
    logic [6:0] chip;
    logic [7:0] sub;
    logic [7:0] dat;
    logic       busy;
    logic [2:0] acks;
    sps_hst_t   st;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [7:0] sh;
    logic       scl_oe;
    logic       sda_oe;
    logic [1:0] sda;
  } sps_host_st_t;

  sps_host_st_t q;
  sps_host_st_t d;
  logic tick;

  always_comb
  begin
    d = q;
    d.sda = {q.sda[0], bus.sda};
    tick = (q.div == 8'(HALF_CYC - 1));
    d.div = tick ? 8'h00 : q.div + 8'h01;

    // Register slave: one wait state, write lands on the completing edge.
    if (psel && penable && !q.rdy)
    begin
      d.rdy = 1'b1;
      d.rdata = 32'h0000_0000;
      if (paddr == SPS_APB_STAT)
        d.rdata = {28'h000_0000, q.acks, q.busy};
      else if (paddr == SPS_APB_ADDR)
        d.rdata = {25'h000_0000, q.chip};
      else if (paddr == SPS_APB_CMD)
        d.rdata = {16'h0000, q.dat, q.sub};
    end
    else if (q.rdy)
    begin
      d.rdy = 1'b0;
      if (psel && penable && pwrite)
      begin
        if (paddr == SPS_APB_ADDR)
          d.chip = pwdata[6:0];
        else if (paddr == SPS_APB_CMD && !q.busy)
        begin
          d.sub = pwdata[SPS_CMD_SUB_LSB +: 8];
          d.dat = pwdata[SPS_CMD_DAT_LSB +: 8];
          d.busy = 1'b1;
          d.acks = 3'h0;
          d.sh = {q.chip, 1'b0};
          d.byten = 2'h0;
          d.bitn = 4'h0;
          d.st = SPS_H_START;
          d.div = 8'h00;
          d.sda_oe = 1'b1;
        end
      end
    end

    // Write transfer: start, three bytes, stop; a missing ack ends it early.
    case (q.st)
      SPS_H_START:
      begin
        if (tick)
        begin
          d.scl_oe = 1'b1;
          d.st = SPS_H_LOW;
        end
      end
      SPS_H_LOW:
      begin
        if (q.div == 8'h00)
          d.sda_oe = (q.bitn < 4'h8) ? ~q.sh[7] : 1'b0;
        if (tick)
        begin
          d.scl_oe = 1'b0;
          d.st = SPS_H_HIGH;
        end
      end
      SPS_H_HIGH:
      begin
        if (tick)
        begin
          d.scl_oe = 1'b1;
          d.st = SPS_H_LOW;
          if (q.bitn == 4'h8)
          begin
            d.acks[q.byten] = ~q.sda[1];
            d.bitn = 4'h0;
            d.byten = q.byten + 2'h1;
            d.sh = (q.byten == 2'h0) ? q.sub : q.dat;
            if (q.sda[1] || q.byten == 2'h2)
              d.st = SPS_H_STOP;
          end
          else
          begin
            d.sh = {q.sh[6:0], 1'b0};
            d.bitn = q.bitn + 4'h1;
          end
        end
      end
      SPS_H_STOP:
      begin
        if (q.div == 8'h00)
          d.sda_oe = 1'b1;
        if (tick)
        begin
          d.scl_oe = 1'b0;
          d.st = SPS_H_FREE;
        end
      end
      SPS_H_FREE:
      begin
        if (tick)
        begin
          d.sda_oe = 1'b0;
          d.busy = 1'b0;
          d.st = SPS_H_IDLE;
        end
      end
      default:
      begin
        d.scl_oe = 1'b0;
        if (!d.busy)
          d.sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.chip <= SPS_CHIP_ADDR;
      q.st <= SPS_H_IDLE;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign bus.host_scl_oe = q.scl_oe;
  assign bus.host_sda_oe = q.sda_oe;
  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = 1'b0;
endmodule // sps_host

// file: rtl/sps_i2c_if.sv
`timescale 1ns/1ps
interface sps_i2c_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires: any enabled driver pulls the line low.
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
  modport dev  (output dev_sda_oe, input scl, input sda);
endinterface

// file: rtl/sps_pkg.sv
package sps_pkg;
  localparam logic [6:0] SPS_CHIP_ADDR  = 7'h46;
  localparam logic [7:0] SPS_SUB_CTRL   = 8'h1A;
  localparam logic [7:0] SPS_CTRL_RST   = 8'h00;
  localparam int         SPS_BIT_SOFT   = 0;
  localparam int         SPS_BIT_STBY   = 1;
  localparam int         SPS_CLK_NS     = 100;
  localparam int         SPS_CLAMP_NS   = 20000;
  localparam int         SPS_VERT_NS    = 20000;
  localparam int         SPS_SCL_HALF_NS = 5000;
  localparam int         SPS_CLAMP_CYC  = (SPS_CLAMP_NS + SPS_CLK_NS - 1) / SPS_CLK_NS;
  localparam int         SPS_VERT_CYC   = (SPS_VERT_NS + SPS_CLK_NS - 1) / SPS_CLK_NS;
  localparam int         SPS_SCL_HALF_CYC = SPS_SCL_HALF_NS / SPS_CLK_NS;
  localparam logic [7:0] SPS_APB_CMD    = 8'h00;
  localparam logic [7:0] SPS_APB_STAT   = 8'h04;
  localparam logic [7:0] SPS_APB_ADDR   = 8'h08;
  localparam int         SPS_CMD_SUB_LSB = 0;
  localparam int         SPS_CMD_DAT_LSB = 8;
  localparam int         SPS_STAT_BUSY  = 0;
  localparam int         SPS_STAT_ACK_LSB = 1;

  typedef enum logic [1:0] {SPS_SEQ_OFF, SPS_SEQ_CLAMP, SPS_SEQ_VERT, SPS_SEQ_RUN} sps_seq_t;
  typedef enum logic [1:0] {SPS_PH_IDLE, SPS_PH_ADDR, SPS_PH_SUB, SPS_PH_DATA} sps_ph_t;
  typedef enum logic [2:0] {SPS_H_IDLE, SPS_H_START, SPS_H_LOW, SPS_H_HIGH, SPS_H_STOP,
                            SPS_H_FREE} sps_hst_t;
endpackage

// file: tb/sps_checker.sv
`timescale 1ns/1ps
module sps_checker #(
  parameter int VERT_CYC = 4
)(
  input wire logic clock,
  input wire logic nrst,
  input wire logic dev_sda_oe,
  input wire logic supply_above_8v3,
  input wire logic supply_above_8v1,
  input wire logic overvoltage_trip_in,
  input wire logic loop_node_grounded,
  input wire logic unlock_status,
  input wire logic horiz_drive_oe,
  input wire logic supply_drive_oe,
  input wire logic vert_out_en,
  input wire logic lock_loss_flag_oe,
  input wire logic clamp_blank_continuous,
  input wire logic loop_filter_discharge,
  input wire logic standby_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_NO_ACK_LOW: assert property ((!supply_above_8v3)[*4] |-> !dev_sda_oe)
    else $error("ack while supply low");
  AST_DIP_STBY: assert property ((!supply_above_8v1)[*4] |-> standby_status)
    else $error("no standby on dip");
  AST_OVP_PROT: assert property (overvoltage_trip_in[*4] |-> clamp_blank_continuous)
    else $error("no protection on trip");
  AST_GND_PROT: assert property (loop_node_grounded[*4] |-> clamp_blank_continuous)
    else $error("no protection on grounded node");
  AST_FLOAT: assert property (clamp_blank_continuous |->
    !(horiz_drive_oe | supply_drive_oe | lock_loss_flag_oe | vert_out_en))
    else $error("output active in protection");
  AST_DISCH: assert property (loop_filter_discharge == clamp_blank_continuous)
    else $error("discharge differs from blanking");
  AST_RUN_ALL: assert property (horiz_drive_oe |->
    supply_drive_oe && vert_out_en && !clamp_blank_continuous)
    else $error("drive before earlier stages");
  AST_LOCK_FLAG: assert property (!clamp_blank_continuous |->
    lock_loss_flag_oe == !$past(unlock_status))
    else $error("lock flag wrong outside protection");
  AST_STBY_RUN: assert property (standby_status != horiz_drive_oe)
    else $error("standby and drive disagree");
  AST_VERT_ORDER: assert property ($rose(horiz_drive_oe) |->
    $past(vert_out_en, VERT_CYC))
    else $error("vertical stage too short");
  AST_CLAMP_FIRST: assert property ($rose(vert_out_en) |->
    !clamp_blank_continuous && $past(lock_loss_flag_oe))
    else $error("vertical before clamp stage");
  cover property ($rose(horiz_drive_oe));
  cover property ($rose(dev_sda_oe));
  cover property ($rose(clamp_blank_continuous));
endmodule // sps_checker

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sps_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ce = 1'b1;
  logic        unlock_status = 1'b0;
  logic        lock_loss_flag_o;
  logic [31:0] rdat;
  logic        supply_above_8v3 = 1'b0;
  logic        supply_above_8v1 = 1'b0;
  logic        overvoltage_trip_in = 1'b0;
  logic        loop_node_grounded = 1'b0;
  logic        horiz_drive_oe, supply_drive_oe, vert_out_en;
  logic        lock_loss_flag_oe, clamp_blank_continuous;
  logic        loop_filter_discharge, standby_status;
  logic [6:0]  outs;
  int          failures = 0;
  int          checked = 0;

  assign outs = {horiz_drive_oe, supply_drive_oe, vert_out_en, lock_loss_flag_oe,
                 clamp_blank_continuous, standby_status, loop_filter_discharge};

  always #50 clock = ~clock;

  sps_i2c_if i_sps_i2c_if();

  sps_dev #(.CLAMP_CYC(4), .VERT_CYC(4)) i_sps_dev (
    .clock, .nrst, .ce, .bus(i_sps_i2c_if.dev), .supply_above_8v3,
    .supply_above_8v1, .overvoltage_trip_in, .loop_node_grounded,
    .unlock_status, .horiz_drive_oe, .supply_drive_oe, .vert_out_en,
    .lock_loss_flag_o, .lock_loss_flag_oe, .clamp_blank_continuous,
    .loop_filter_discharge, .standby_status);

  sps_host #(.HALF_CYC(4)) i_sps_host (
    .clock, .nrst, .ce, .bus(i_sps_i2c_if.host), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  sps_checker #(.VERT_CYC(4)) i_sps_checker (
    .clock, .nrst, .dev_sda_oe(i_sps_i2c_if.dev_sda_oe), .supply_above_8v3,
    .supply_above_8v1, .overvoltage_trip_in, .loop_node_grounded, .unlock_status,
    .horiz_drive_oe, .supply_drive_oe, .vert_out_en, .lock_loss_flag_oe,
    .clamp_blank_continuous, .loop_filter_discharge, .standby_status);

  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      test_done();
    end
  endtask

  // Sends one data byte to a subaddress and compares the three ack bits.
  task automatic xfer(input logic [7:0] sub, input logic [7:0] dat, input logic [2:0] ack,
                      input int hold = 0);
    int n;
    logic [8:0] lines;
    apb(1'b1, SPS_APB_CMD, {16'h0000, dat, sub});
    // A pause with the clock enable low must leave the link and outputs still.
    if (hold > 0)
    begin
      ce <= 1'b0;
      @(posedge clock);
      lines = {i_sps_i2c_if.scl, i_sps_i2c_if.sda, outs};
      repeat (hold) @(posedge clock);
      chk("frozen", {23'h0, lines}, {23'h0, i_sps_i2c_if.scl, i_sps_i2c_if.sda, outs});
      ce <= 1'b1;
    end
    n = 0;
    do
    begin
      apb(1'b0, SPS_APB_STAT, 32'h0);
      n++;
    end
    while (rdat[SPS_STAT_BUSY] !== 1'b0 && n < 500);
    if (rdat[SPS_STAT_BUSY] !== 1'b0)
    begin
      failures++;
      test_done();
    end
    chk("ack", {29'h0, ack}, {29'h0, rdat[3:1]});
  endtask

  // Waits for the drives to reach the given state.
  task automatic run(input logic e);
    int n;
    n = 0;
    while (horiz_drive_oe !== e && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    chk("outs", e ? 32'h78 : 32'h07, {25'h0, outs});
    if (horiz_drive_oe !== e)
    begin
      failures++;
      test_done();
    end
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    xfer(SPS_SUB_CTRL, 8'h01, 3'b000);
    chk("outs", 32'h07, {25'h0, outs});
    supply_above_8v3 <= 1'b1;
    supply_above_8v1 <= 1'b1;
    repeat (6) @(posedge clock);
    xfer(8'h05, 8'h55, 3'b011);
    xfer(SPS_SUB_CTRL, 8'h01, 3'b111);
    xfer(SPS_SUB_CTRL, 8'h01, 3'b111);
    run(1'b1);
    xfer(8'h05, 8'h55, 3'b111, 50);
    unlock_status <= 1'b1;
    repeat (3) @(posedge clock);
    chk("unlock", 32'h70, {25'h0, outs});
    unlock_status <= 1'b0;
    repeat (3) @(posedge clock);
    chk("relock", 32'h78, {25'h0, outs});
    overvoltage_trip_in <= 1'b1;
    repeat (6) @(posedge clock);
    overvoltage_trip_in <= 1'b0;
    repeat (20) @(posedge clock);
    chk("outs", 32'h07, {25'h0, outs});
    xfer(SPS_SUB_CTRL, 8'h01, 3'b111);
    xfer(SPS_SUB_CTRL, 8'h01, 3'b111);
    run(1'b1);
    loop_node_grounded <= 1'b1;
    repeat (6) @(posedge clock);
    chk("outs", 32'h07, {25'h0, outs});
    loop_node_grounded <= 1'b0;
    run(1'b1);
    supply_above_8v1 <= 1'b0;
    supply_above_8v3 <= 1'b0;
    repeat (6) @(posedge clock);
    chk("outs", 32'h07, {25'h0, outs});
    supply_above_8v3 <= 1'b1;
    supply_above_8v1 <= 1'b1;
    repeat (6) @(posedge clock);
    xfer(8'h05, 8'h55, 3'b011);
    xfer(SPS_SUB_CTRL, 8'h00, 3'b111);
    xfer(SPS_SUB_CTRL, 8'h01, 3'b111);
    run(1'b1);
    xfer(SPS_SUB_CTRL, 8'h02, 3'b111);
    run(1'b0);
    xfer(SPS_SUB_CTRL, 8'h00, 3'b111);
    xfer(SPS_SUB_CTRL, 8'h01, 3'b111);
    run(1'b1);
    apb(1'b0, SPS_APB_ADDR, 32'h0);
    chk("addr", {25'h0, SPS_CHIP_ADDR}, rdat);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rdat);
    chk("flag_o", 32'h0, {31'h0, lock_loss_flag_o});
    chk("pslverr", 32'h0, {31'h0, pslverr});
    test_done();
  end
endmodule // testbench
